// ==== dv/prv_program_rom_chk.sv ====
// Concurrent checks on the program ROM block ports.
// Assumes binding into prv_program_rom; single clock, srst domain.
`timescale 1ns/1ps
module prv_program_rom_chk
    import prv_pkg::*;
#(
    parameter int unsigned WORDS = ROM_WORDS,
    parameter int unsigned DEPTH = STACK_DEPTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wdt_reset_req,
    input wire logic ext_reset_req,
    input wire logic irq_req,
    input wire logic [15:0] fetch_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    chk_ready_access: assert property (psel && penable |-> pready)
        else $error("access cycle without ready");
    chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
        else $error("ready outside one access cycle");
    chk_rd_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside a read answer");
    chk_err_unmapped: assert property (pready && paddr > OFS_STAT |-> pslverr)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (pready && paddr <= OFS_STAT
        && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    chk_por_vec: assert property ($fell(srst) |-> fetch_addr == RESET_VEC)
        else $error("fetch not at zero after power-on");
    chk_pin_vec: assert property ($rose(wdt_reset_req) ||
        $rose(ext_reset_req) |-> ##[1:5] fetch_addr == RESET_VEC)
        else $error("fetch not at zero after pin reset");
    chk_irq_vec: assert property ($rose(irq_req) && !wdt_reset_req
        && !ext_reset_req |-> ##[1:5] fetch_addr == IRQ_VEC)
        else $error("fetch not at interrupt vector");
endmodule : prv_program_rom_chk
bind prv_program_rom prv_program_rom_chk #(.WORDS(WORDS), .DEPTH(DEPTH))
    u_chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdt_reset_req(wdt_reset_req),
    .ext_reset_req(ext_reset_req), .irq_req(irq_req),
    .fetch_addr(fetch_addr));

// ==== dv/prv_program_rom_tb.sv ====
// Self-checking bench for the program ROM block over APB.
// Assumes the design package and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module prv_program_rom_tb import prv_pkg::*; ();
    logic clk, srst, psel, penable, pwrite, pready, pslverr, e;
    logic wdt_reset_req, ext_reset_req, irq_req;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] fetch_addr;
    int mismatches, n_tests;
    prv_program_rom dut (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdt_reset_req(wdt_reset_req), .ext_reset_req(ext_reset_req),
        .irq_req(irq_req), .fetch_addr(fetch_addr));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rv, output logic ev);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            test_done();
        end
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0, r, e);
        `CHK(r, x)
    endtask : rd
    // Table read from {y, z}, then low and high bytes compared
    task automatic tbl(input logic [7:0] y, input logic [7:0] z,
        input logic [31:0] lo, input logic [31:0] hi);
        wr(OFS_YIDX, {24'h0, y});
        wr(OFS_ZIDX, {24'h0, z});
        wr(OFS_CMD, 32'h1 << CMD_TBLRD);
        rd(OFS_ACC, lo);
        rd(OFS_HIDATA, hi);
    endtask : tbl
    // Pulses one request pin, then waits for the expected fetch address
    task automatic pin(input int k, input logic [15:0] pc);
        int n;
        @(posedge clk);
        irq_req <= (k == 0);
        wdt_reset_req <= (k == 1);
        ext_reset_req <= (k == 2);
        repeat (2) @(posedge clk);
        {irq_req, wdt_reset_req, ext_reset_req} <= 3'h0;
        for (n = 0; n < 10 && fetch_addr !== pc; n++) @(posedge clk);
        `CHK(fetch_addr, pc)
        if (n == 10) test_done();
    endtask : pin
    initial begin
        {srst, psel, penable, pwrite} = 4'h8;
        {wdt_reset_req, ext_reset_req, irq_req} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mismatches = 0;
        n_tests = 0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rd(OFS_PC, 32'h0);
        rd(OFS_FLAG, 32'h80);
        xfer(1'b0, 8'h30, 32'h0, r, e);
        `CHK({e, r}, 33'h1_0000_0000)
        wr(OFS_ROMADR, 32'h10);
        wr(OFS_ROMDAT, 32'h0035);
        wr(OFS_ROMDAT, 32'h5105);
        wr(OFS_ROMDAT, 32'h2012);
        wr(OFS_ROMADR, 32'h17FC);
        wr(OFS_ROMDAT, 32'hABCD);
        wr(OFS_ROMDAT, 32'h1234);
        rd(OFS_ROMADR, 32'h17FE);
        wr(OFS_ROMADR, 32'h11);
        rd(OFS_ROMDAT, 32'h5105);
        tbl(8'h00, 8'h11, 32'h05, 32'h51);
        tbl(8'h00, 8'h10, 32'h35, 32'h00);
        tbl(8'h17, 8'hFC, 32'hCD, 32'hAB);
        tbl(8'h17, 8'hFD, 32'h00, 32'h00);
        wr(OFS_ZIDX, 32'hFF);
        wr(OFS_ZIDX, 32'h00);
        rd(OFS_YIDX, 32'h17);
        wr(OFS_PC, 32'h0123);
        pin(0, IRQ_VEC);
        rd(OFS_STAT, 32'h10);
        wr(OFS_CMD, 32'h1 << CMD_RETI);
        rd(OFS_PC, 32'h0123);
        wr(OFS_ACC, 32'h11);
        wr(OFS_FLAG, 32'h05);
        wr(OFS_CMD, 32'h1 << CMD_SAVE);
        wr(OFS_ACC, 32'h22);
        wr(OFS_FLAG, 32'h0A);
        wr(OFS_CMD, 32'h1 << CMD_SAVE);
        wr(OFS_ACC, 32'h33);
        wr(OFS_FLAG, 32'hFF);
        rd(OFS_FLAG, 32'hBF);
        wr(OFS_CMD, 32'h1 << CMD_RESTORE);
        rd(OFS_ACC, 32'h22);
        rd(OFS_FLAG, 32'h8A);
        wr(OFS_PC, 32'h40);
        wr(OFS_CMD, (32'h1 << CMD_STEP) | (32'h1 << CMD_IRQ));
        rd(OFS_PC, 32'h08);
        wr(OFS_CMD, 32'h1 << CMD_RETI);
        rd(OFS_PC, 32'h41);
        pin(1, RESET_VEC);
        rd(OFS_FLAG, 32'h00);
        rd(OFS_ACC, 32'h00);
        wr(OFS_PC, 32'h55);
        pin(2, RESET_VEC);
        rd(OFS_FLAG, 32'hC0);
        test_done();
    end
endmodule : prv_program_rom_tb

// ==== hdl/prv_pkg.sv ====
// Constants, offsets and field positions of the program ROM vector block.
// Assumes a 10 MHz core clock and an APB master with 32-bit data.
package prv_pkg;

    // -------------------------------------------------------------
    // Memory map of program space
    // -------------------------------------------------------------
    localparam int unsigned ROM_WORDS = 6144;
    localparam int unsigned ROM_RSVD = 3;
    localparam logic [15:0] RESET_VEC = 16'h0000;
    localparam logic [15:0] IRQ_VEC = 16'h0008;
    localparam logic [15:0] USER_END = 16'(ROM_WORDS - ROM_RSVD - 1);
    localparam int unsigned STACK_DEPTH = 8;

    // -------------------------------------------------------------
    // APB register offsets (byte addresses)
    // -------------------------------------------------------------
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_PC = 8'h04;
    localparam logic [7:0] OFS_ACC = 8'h08;
    localparam logic [7:0] OFS_FLAG = 8'h0C;
    localparam logic [7:0] OFS_YIDX = 8'h10;
    localparam logic [7:0] OFS_ZIDX = 8'h14;
    localparam logic [7:0] OFS_HIDATA = 8'h18;
    localparam logic [7:0] OFS_ROMADR = 8'h1C;
    localparam logic [7:0] OFS_ROMDAT = 8'h20;
    localparam logic [7:0] OFS_STAT = 8'h24;

    // -------------------------------------------------------------
    // Command register bits (write one to act, read as zero)
    // -------------------------------------------------------------
    localparam int unsigned CMD_STEP = 0;
    localparam int unsigned CMD_IRQ = 1;
    localparam int unsigned CMD_RETI = 2;
    localparam int unsigned CMD_SAVE = 3;
    localparam int unsigned CMD_RESTORE = 4;
    localparam int unsigned CMD_TBLRD = 5;

    // -------------------------------------------------------------
    // Flag register layout
    // -------------------------------------------------------------
    localparam int unsigned FLG_TIMEOUT = 7;
    localparam int unsigned FLG_PWRDN = 6;
    localparam logic [7:0] FLG_SW_MASK = 8'h3F;
    localparam logic [7:0] FLG_CAUSE_MASK = 8'hC0;
    localparam logic [7:0] FLG_POR = 8'h80;
    localparam logic [7:0] FLG_WDT = 8'h00;
    localparam logic [7:0] FLG_EXT = 8'hC0;

endpackage : prv_pkg

// ==== hdl/prv_program_rom.sv ====
// Program ROM, vector sequencing, context buffer and table read.
// Assumes an APB master on clk; reset request pins are asynchronous.
`timescale 1ns/1ps

module prv_program_rom
    import prv_pkg::*;
#(
    parameter int unsigned WORDS = ROM_WORDS,
    parameter int unsigned DEPTH = STACK_DEPTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wdt_reset_req,
    input wire logic ext_reset_req,
    input wire logic irq_req,
    output logic [15:0] fetch_addr
);

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    localparam int unsigned SPW = $clog2(DEPTH);

    typedef struct packed {
        logic [WORDS-1:0][15:0] rom;
        logic [DEPTH-1:0][15:0] stack;
        logic [SPW-1:0] sp;
        logic [15:0] pc;
        logic [7:0] acc;
        logic [7:0] flags;
        logic [7:0] y_idx;
        logic [7:0] z_idx;
        logic [7:0] hi_data;
        logic [7:0] save_acc;
        logic [7:0] save_flags;
        logic save_valid;
        logic [15:0] rom_adr;
        logic [2:0] wdt_sync;
        logic [2:0] ext_sync;
        logic [2:0] irq_sync;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } prv_state_s;

    prv_state_s st_q;
    prv_state_s st_d;

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    function automatic logic in_rom(input logic [15:0] a);
        in_rom = (32'(a) < WORDS);
    endfunction : in_rom

    function automatic logic user_space(input logic [15:0] a);
        user_space = (a <= USER_END) && in_rom(a);
    endfunction : user_space

    function automatic logic mapped(input logic [7:0] a);
        unique case (a)
            OFS_CMD, OFS_PC, OFS_ACC, OFS_FLAG, OFS_YIDX, OFS_ZIDX,
            OFS_HIDATA, OFS_ROMADR, OFS_ROMDAT, OFS_STAT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    function automatic logic [15:0] rom_word(input prv_state_s s,
                                             input logic [15:0] a);
        if (in_rom(a)) begin
            rom_word = s.rom[a[12:0]];
        end else begin
            rom_word = 16'h0000;
        end
    endfunction : rom_word

    function automatic logic [31:0] read_mux(input prv_state_s s,
                                             input logic [7:0] a);
        read_mux = 32'h0000_0000;
        unique case (a)
            OFS_PC: read_mux = {16'h0000, s.pc};
            OFS_ACC: read_mux = {24'h00_0000, s.acc};
            OFS_FLAG: read_mux = {24'h00_0000, s.flags};
            OFS_YIDX: read_mux = {24'h00_0000, s.y_idx};
            OFS_ZIDX: read_mux = {24'h00_0000, s.z_idx};
            OFS_HIDATA: read_mux = {24'h00_0000, s.hi_data};
            OFS_ROMADR: read_mux = {16'h0000, s.rom_adr};
            OFS_ROMDAT: read_mux = {16'h0000, rom_word(s, s.rom_adr)};
            OFS_STAT: read_mux = {23'h00_0000, s.save_valid,
                                  4'(s.sp), 4'h0};
            default: read_mux = 32'h0000_0000;
        endcase
    endfunction : read_mux

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    logic apb_setup;
    logic apb_write;
    logic wdt_evt;
    logic ext_evt;
    logic irq_evt;
    logic [31:0] wd;
    logic [15:0] tbl_adr;
    logic [15:0] tbl_word;

    always_comb begin
        st_d = st_q;
        apb_setup = psel && !penable;
        apb_write = psel && penable && st_q.pready && pwrite;
        wd = pwdata;
        tbl_adr = {st_q.y_idx, st_q.z_idx};
        tbl_word = rom_word(st_q, tbl_adr);

        // Three-stage synchronisers; stage 2 and 3 feed the edge detect
        st_d.wdt_sync = {st_q.wdt_sync[1:0], wdt_reset_req};
        st_d.ext_sync = {st_q.ext_sync[1:0], ext_reset_req};
        st_d.irq_sync = {st_q.irq_sync[1:0], irq_req};
        wdt_evt = st_q.wdt_sync[1] && !st_q.wdt_sync[2];
        ext_evt = st_q.ext_sync[1] && !st_q.ext_sync[2];
        irq_evt = st_q.irq_sync[1] && !st_q.irq_sync[2];

        // APB slave: answer in the first access cycle
        st_d.pready = apb_setup;
        if (apb_setup) begin
            st_d.prdata = pwrite ? 32'h0000_0000 : read_mux(st_q, paddr);
            st_d.pslverr = !mapped(paddr);
        end else begin
            // Answer stands for the one access cycle only
            st_d.prdata = 32'h0000_0000;
            st_d.pslverr = 1'b0;
        end

        if (apb_write) begin
            unique case (paddr)
                OFS_CMD: begin
                    if (wd[CMD_STEP]) begin
                        st_d.pc = st_q.pc + 16'h0001;
                    end
                    if (wd[CMD_RETI]) begin
                        st_d.sp = st_q.sp - SPW'(1);
                        st_d.pc = st_q.stack[st_q.sp - SPW'(1)];
                    end
                    if (wd[CMD_SAVE]) begin
                        // Single slot, a later save replaces it
                        st_d.save_acc = st_q.acc;
                        st_d.save_flags = st_q.flags & FLG_SW_MASK;
                        st_d.save_valid = 1'b1;
                    end
                    if (wd[CMD_RESTORE]) begin
                        st_d.acc = st_q.save_acc;
                        st_d.flags = (st_q.flags & FLG_CAUSE_MASK)
                                   | (st_q.save_flags & FLG_SW_MASK);
                        st_d.save_valid = 1'b0;
                    end
                    if (wd[CMD_TBLRD]) begin
                        st_d.acc = tbl_word[7:0];
                        st_d.hi_data = tbl_word[15:8];
                        st_d.pc = st_q.pc + 16'h0001;
                    end
                end
                OFS_PC: st_d.pc = wd[15:0];
                OFS_ACC: st_d.acc = wd[7:0];
                OFS_FLAG: begin
                    st_d.flags = (st_q.flags & FLG_CAUSE_MASK)
                               | (wd[7:0] & FLG_SW_MASK);
                end
                // Index registers load independently, no carry between
                OFS_YIDX: st_d.y_idx = wd[7:0];
                OFS_ZIDX: st_d.z_idx = wd[7:0];
                OFS_ROMADR: st_d.rom_adr = wd[15:0];
                OFS_ROMDAT: begin
                    // Reserved top words and out-of-range stay untouched
                    if (user_space(st_q.rom_adr)) begin
                        st_d.rom[st_q.rom_adr[12:0]] = wd[15:0];
                    end
                    st_d.rom_adr = st_q.rom_adr + 16'h0001;
                end
                default: begin
                end
            endcase
        end

        // Interrupt acceptance from pin or command
        if (irq_evt || (apb_write && paddr == OFS_CMD && wd[CMD_IRQ])) begin
            st_d.stack[st_q.sp] = st_d.pc;
            st_d.sp = st_q.sp + SPW'(1);
            st_d.pc = IRQ_VEC;
        end

        // Watchdog and external restart: ROM contents survive
        if (wdt_evt || ext_evt) begin
            st_d.pc = RESET_VEC;
            st_d.sp = '0;
            st_d.acc = 8'h00;
            st_d.y_idx = 8'h00;
            st_d.z_idx = 8'h00;
            st_d.hi_data = 8'h00;
            st_d.save_acc = 8'h00;
            st_d.save_flags = 8'h00;
            st_d.save_valid = 1'b0;
            st_d.rom_adr = 16'h0000;
            // External wins when both arrive together
            st_d.flags = ext_evt ? FLG_EXT : FLG_WDT;
        end
    end

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '0;
            st_q.pc <= RESET_VEC;
            st_q.flags <= FLG_POR;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign fetch_addr = st_q.pc;

endmodule : prv_program_rom
